/* File: inc/fws_defines.vh */
`ifndef FWS_DEFINES_VH
`define FWS_DEFINES_VH

// ------------------------------------------------------------
// register indices on the software port
// ------------------------------------------------------------
`define FWS_REG_CTRL     4'h0
`define FWS_REG_ADDR     4'h1
`define FWS_REG_WDATA    4'h2
`define FWS_REG_RDATA    4'h3
`define FWS_REG_IRQ_STS  4'h4
`define FWS_REG_IRQ_MASK 4'h5
`define FWS_REG_LAST     4'h6

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define FWS_CTRL_OP_LSB  0
`define FWS_CTRL_OP_MSB  2
`define FWS_CTRL_ABORT   3
`define FWS_CTRL_IGN_WIN 4
`define FWS_CTRL_BUSY    8
`define FWS_CTRL_RST     32'h0000_0000

// operation codes written to the control register
`define FWS_OP_NONE      3'h0
`define FWS_OP_READ      3'h1
`define FWS_OP_WRITE     3'h2
`define FWS_OP_POLL      3'h3
`define FWS_OP_ADD_SEC   3'h4
`define FWS_OP_RESET     3'h5

// ------------------------------------------------------------
// interrupt status bits
// ------------------------------------------------------------
`define FWS_IRQ_DONE     0
`define FWS_IRQ_FAIL     1
`define FWS_IRQ_REJECT   2
`define FWS_IRQ_ABORT    3
`define FWS_IRQ_W        4
`define FWS_IRQ_RST      4'h0

// ------------------------------------------------------------
// status byte bit positions on the flash data bus
// ------------------------------------------------------------
`define FWS_POLL_STATUS_BIT   7
`define FWS_TOGGLE_STATUS_BIT 6
`define FWS_TIMEOUT_FAIL_BIT  5
`define FWS_ERASE_WINDOW_BIT  3
`define FWS_SECTOR_TOGGLE_BIT 2

// flash command bytes
`define FWS_CMD_RESET    8'hF0
`define FWS_CMD_SEC_ERASE 8'h30

// ------------------------------------------------------------
// bus cycle timing
// ------------------------------------------------------------
`define FWS_CLK_NS       40
`define FWS_T_ACC_NS     70
`define FWS_T_OEH_NS     10
`define FWS_T_WP_NS      45
`define FWS_CEIL_CYC(ns) (((ns) + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_RD_CYC       `FWS_CEIL_CYC(`FWS_T_ACC_NS)
`define FWS_WR_CYC       `FWS_CEIL_CYC(`FWS_T_WP_NS)
`define FWS_GAP_CYC      `FWS_CEIL_CYC(`FWS_T_OEH_NS)

`endif

/* File: hdl/fws_cycle.v */
`include "fws_defines.vh"

// one read or write cycle on the parallel flash pins
module fws_cycle
#(
  parameter       AW      = 19,
  parameter [31:0] RD_CYC  = `FWS_RD_CYC,
  parameter [31:0] WR_CYC  = `FWS_WR_CYC,
  parameter [31:0] GAP_CYC = `FWS_GAP_CYC
)
(
  input  wire          clk_sys_i,
  input  wire          nrst_i,
  input  wire          start_i,
  input  wire          wr_i,
  input  wire [AW-1:0] addr_i,
  input  wire [7:0]    wdata_i,
  output reg           done_o,
  output reg  [7:0]    rdata_o,
  output reg  [AW-1:0] fl_addr_o,
  input  wire [7:0]    fl_dq_i,
  output reg  [7:0]    fl_dq_o,
  output reg           fl_dq_oe_n_o,
  output reg           fl_ce_n_o,
  output reg           fl_oe_n_o,
  output reg           fl_we_n_o
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_SET  = 4'b0010;
  localparam [3:0] ST_STB  = 4'b0100;
  localparam [3:0] ST_GAP  = 4'b1000;

  reg [3:0] state_r;
  reg [3:0] cnt_r;
  reg       wr_r;

  // ------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------
  // address and chip enable settle one clock before the strobe falls;
  // strobes then rise together with chip enable, and a gap of at least
  // the output enable hold time follows so toggle reads stay distinct
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r      <= ST_IDLE;
      cnt_r        <= 4'h0;
      wr_r         <= 1'b0;
      done_o       <= 1'b0;
      rdata_o      <= 8'h00;
      fl_addr_o    <= {AW{1'b0}};
      fl_dq_o      <= 8'h00;
      fl_dq_oe_n_o <= 1'b1;
      fl_ce_n_o    <= 1'b1;
      fl_oe_n_o    <= 1'b1;
      fl_we_n_o    <= 1'b1;
    end
    else
    begin
      done_o <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (start_i)
          begin
            wr_r         <= wr_i;
            fl_addr_o    <= addr_i;
            fl_dq_o      <= wdata_i;
            fl_dq_oe_n_o <= ~wr_i;   // drive data only for writes
            fl_ce_n_o    <= 1'b0;
            state_r      <= ST_SET;
          end
        end
        ST_SET:
        begin
          fl_we_n_o <= ~wr_r;
          fl_oe_n_o <= wr_r;
          cnt_r     <= wr_r ? WR_CYC[3:0] : RD_CYC[3:0];  // counts fit four bits
          state_r   <= ST_STB;
        end
        ST_STB:
        begin
          if (cnt_r <= 4'h1)
          begin
            fl_we_n_o <= 1'b1;
            fl_oe_n_o <= 1'b1;
            fl_ce_n_o <= 1'b1;
            if (!wr_r)
              rdata_o <= fl_dq_i;  // sampled at the last strobe edge
            cnt_r   <= GAP_CYC[3:0];
            state_r <= ST_GAP;
          end
          else
            cnt_r <= cnt_r - 4'h1;
        end
        ST_GAP:
        begin
          if (cnt_r <= 4'h1)
          begin
            fl_dq_oe_n_o <= 1'b1;
            done_o       <= 1'b1;
            state_r      <= ST_IDLE;
          end
          else
            cnt_r <= cnt_r - 4'h1;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

endmodule

/* File: hdl/fws_host.v */
// ------------------------------------------------------------
// ------------------------------------------------------------
`include "fws_defines.vh"

module fws_host
#(
  parameter AW = 19
)
(
  input  wire          clk_sys_i,
  input  wire          nrst_i,
  input  wire [3:0]    reg_addr_i,
  input  wire [31:0]   reg_wdata_i,
  input  wire          reg_wr_i,
  input  wire          reg_rd_i,
  output reg  [31:0]   reg_rdata_o,
  output reg           irq_o,
  output wire [AW-1:0] fl_addr_o,
  input  wire [7:0]    fl_dq_i,
  output wire [7:0]    fl_dq_o,
  output wire          fl_dq_oe_n_o,
  output wire          fl_ce_n_o,
  output wire          fl_oe_n_o,
  output wire          fl_we_n_o
);

  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  localparam [9:0] S_IDLE = 10'b00_0000_0001;
  localparam [9:0] S_ONE  = 10'b00_0000_0010;  // single read or write
  localparam [9:0] S_P1   = 10'b00_0000_0100;  // first status read
  localparam [9:0] S_P2   = 10'b00_0000_1000;  // compare reads
  localparam [9:0] S_R1   = 10'b00_0001_0000;  // recheck, first read
  localparam [9:0] S_R2   = 10'b00_0010_0000;  // recheck, second read
  localparam [9:0] S_RST  = 10'b00_0100_0000;  // reset command write
  localparam [9:0] S_WB   = 10'b00_1000_0000;  // window check before
  localparam [9:0] S_WC   = 10'b01_0000_0000;  // added sector erase write
  localparam [9:0] S_WA   = 10'b10_0000_0000;  // window check after

  reg [9:0]    state_r;
  reg          wait_r;
  reg          cyc_start_r;
  reg          cyc_wr_r;
  reg [7:0]    cyc_wdata_r;
  reg [AW-1:0] cyc_addr_r;
  reg [2:0]    op_r;
  reg          ign_win_r;
  reg          abort_r;
  reg [AW-1:0] addr_r;
  reg [7:0]    wdata_r;
  reg [7:0]    rdata_r;
  reg [7:0]    prev_r;
  reg [7:0]    last_r;
  reg [`FWS_IRQ_W-1:0] sts_r;
  reg [`FWS_IRQ_W-1:0] sts_set;
  reg [`FWS_IRQ_W-1:0] mask_r;

  wire       cyc_done;
  wire [7:0] cyc_rdata;

  wire ctrl_wr = reg_wr_i && (reg_addr_i == `FWS_REG_CTRL);
  wire [2:0] op_req = reg_wdata_i[`FWS_CTRL_OP_MSB:`FWS_CTRL_OP_LSB];
  wire busy = (state_r != S_IDLE);

  // two status reads differ in the toggle status bit
  function toggled;
    input [7:0] a;
    input [7:0] b;
    begin
      toggled = a[`FWS_TOGGLE_STATUS_BIT] ^ b[`FWS_TOGGLE_STATUS_BIT];
    end
  endfunction

  // ------------------------------------------------------------
  // flash bus cycle engine
  // ------------------------------------------------------------
  fws_cycle #(
    .AW (AW)
  ) u_cycle (
    .clk_sys_i    (clk_sys_i),
    .nrst_i       (nrst_i),
    .start_i      (cyc_start_r),
    .wr_i         (cyc_wr_r),
    .addr_i       (cyc_addr_r),
    .wdata_i      (cyc_wdata_r),
    .done_o       (cyc_done),
    .rdata_o      (cyc_rdata),
    .fl_addr_o    (fl_addr_o),
    .fl_dq_i      (fl_dq_i),
    .fl_dq_o      (fl_dq_o),
    .fl_dq_oe_n_o (fl_dq_oe_n_o),
    .fl_ce_n_o    (fl_ce_n_o),
    .fl_oe_n_o    (fl_oe_n_o),
    .fl_we_n_o    (fl_we_n_o)
  );

  // ------------------------------------------------------------
  // operation sequencer
  // ------------------------------------------------------------
  // each state but S_IDLE launches one bus cycle whenever wait_r is low and
  // acts when the engine reports it done; status reads use the programmed
  // address so poll and sector toggle bits are meaningful as well
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r     <= S_IDLE;
      wait_r      <= 1'b0;
      cyc_start_r <= 1'b0;
      cyc_wr_r    <= 1'b0;
      cyc_wdata_r <= 8'h00;
      cyc_addr_r  <= {AW{1'b0}};
      op_r        <= `FWS_OP_NONE;
      ign_win_r   <= 1'b0;
      abort_r     <= 1'b0;
      rdata_r     <= 8'h00;
      prev_r      <= 8'h00;
      last_r      <= 8'h00;
      sts_set     <= {`FWS_IRQ_W{1'b0}};
    end
    else
    begin
      cyc_start_r <= 1'b0;
      sts_set     <= {`FWS_IRQ_W{1'b0}};
      // abort request is held until the poll loop can act on it
      if (ctrl_wr && reg_wdata_i[`FWS_CTRL_ABORT] && busy)
        abort_r <= 1'b1;
      if (!wait_r && state_r != S_IDLE)
      begin
        wait_r      <= 1'b1;
        cyc_start_r <= 1'b1;
        cyc_addr_r  <= addr_r;
        cyc_wr_r    <= (state_r == S_RST) || (state_r == S_WC) ||
                       (state_r == S_ONE && op_r == `FWS_OP_WRITE);
        cyc_wdata_r <= (state_r == S_RST) ? `FWS_CMD_RESET :
                       (state_r == S_WC)  ? `FWS_CMD_SEC_ERASE : wdata_r;
      end
      case (state_r)
        S_IDLE:
        begin
          abort_r <= 1'b0;
          wait_r  <= 1'b0;
          if (ctrl_wr && op_req != `FWS_OP_NONE)
          begin
            op_r      <= op_req;
            ign_win_r <= reg_wdata_i[`FWS_CTRL_IGN_WIN];
            case (op_req)
              `FWS_OP_READ, `FWS_OP_WRITE: state_r <= S_ONE;
              `FWS_OP_POLL:                state_r <= S_P1;
              `FWS_OP_RESET:               state_r <= S_RST;
              `FWS_OP_ADD_SEC:
                state_r <= reg_wdata_i[`FWS_CTRL_IGN_WIN] ? S_WC : S_WB;
              default:                     state_r <= S_IDLE;
            endcase
          end
        end
        S_ONE:
        begin
          if (cyc_done)
          begin
            wait_r  <= 1'b0;
            rdata_r <= cyc_rdata;
            sts_set[`FWS_IRQ_DONE] <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_P1:
        begin
          if (cyc_done)
          begin
            wait_r  <= 1'b0;
            prev_r  <= cyc_rdata;
            last_r  <= cyc_rdata;
            state_r <= S_P2;
          end
        end
        S_P2:
        begin
          if (cyc_done)
          begin
            wait_r  <= 1'b0;
            prev_r  <= cyc_rdata;
            last_r  <= cyc_rdata;
            if (!toggled(prev_r, cyc_rdata))
            begin
              // stable bit: finished, array data follows on next read
              sts_set[`FWS_IRQ_DONE] <= 1'b1;
              state_r <= S_IDLE;
            end
            else if (cyc_rdata[`FWS_TIMEOUT_FAIL_BIT])
              state_r <= S_R1;
            else if (abort_r)
            begin
              // leaving the loop drops history; a new poll starts over
              sts_set[`FWS_IRQ_ABORT] <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        end
        S_R1:
        begin
          if (cyc_done)
          begin
            wait_r  <= 1'b0;
            prev_r  <= cyc_rdata;
            last_r  <= cyc_rdata;
            state_r <= S_R2;
          end
        end
        S_R2:
        begin
          if (cyc_done)
          begin
            wait_r <= 1'b0;
            last_r <= cyc_rdata;
            if (toggled(prev_r, cyc_rdata))
              state_r <= S_RST;
            else
            begin
              // bit stopped just as the timeout bit rose: success
              sts_set[`FWS_IRQ_DONE] <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        end
        S_RST:
        begin
          if (cyc_done)
          begin
            wait_r <= 1'b0;
            sts_set[`FWS_IRQ_DONE] <= 1'b1;
            if (op_r == `FWS_OP_POLL)
              sts_set[`FWS_IRQ_FAIL] <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_WB:
        begin
          if (cyc_done)
          begin
            wait_r <= 1'b0;
            last_r <= cyc_rdata;
            if (cyc_rdata[`FWS_ERASE_WINDOW_BIT])
            begin
              // window closed: the device would ignore the command
              sts_set[`FWS_IRQ_REJECT] <= 1'b1;
              sts_set[`FWS_IRQ_DONE]   <= 1'b1;
              state_r <= S_IDLE;
            end
            else
              state_r <= S_WC;
          end
        end
        S_WC:
        begin
          if (cyc_done)
          begin
            wait_r  <= 1'b0;
            state_r <= ign_win_r ? S_IDLE : S_WA;
            if (ign_win_r)
              sts_set[`FWS_IRQ_DONE] <= 1'b1;
          end
        end
        S_WA:
        begin
          if (cyc_done)
          begin
            wait_r <= 1'b0;
            last_r <= cyc_rdata;
            if (cyc_rdata[`FWS_ERASE_WINDOW_BIT])
              sts_set[`FWS_IRQ_REJECT] <= 1'b1;
            sts_set[`FWS_IRQ_DONE] <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  // address and data may be rewritten only while idle, so a cycle in
  // flight never sees them change underneath it
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      addr_r  <= {AW{1'b0}};
      wdata_r <= 8'h00;
      mask_r  <= `FWS_IRQ_RST;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `FWS_REG_ADDR && !busy)
        addr_r <= reg_wdata_i[AW-1:0];
      if (reg_addr_i == `FWS_REG_WDATA && !busy)
        wdata_r <= reg_wdata_i[7:0];
      if (reg_addr_i == `FWS_REG_IRQ_MASK)
        mask_r <= reg_wdata_i[`FWS_IRQ_W-1:0];
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sts_r <= `FWS_IRQ_RST;
    else if (reg_wr_i && reg_addr_i == `FWS_REG_IRQ_STS)
      sts_r <= (sts_r & ~reg_wdata_i[`FWS_IRQ_W-1:0]) | sts_set;
    else
      sts_r <= sts_r | sts_set;
  end

  // level interrupt, one clock behind the status bits
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(sts_r & mask_r);
  end

  // read data stands only in the cycle after the read strobe
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `FWS_REG_CTRL:
          reg_rdata_o <= {23'h00_0000, busy, 3'h0, ign_win_r, abort_r, op_r};
        `FWS_REG_ADDR:     reg_rdata_o <= {{(32-AW){1'b0}}, addr_r};
        `FWS_REG_WDATA:    reg_rdata_o <= {24'h00_0000, wdata_r};
        `FWS_REG_RDATA:    reg_rdata_o <= {24'h00_0000, rdata_r};
        `FWS_REG_IRQ_STS:  reg_rdata_o <= {{(32-`FWS_IRQ_W){1'b0}}, sts_r};
        `FWS_REG_IRQ_MASK: reg_rdata_o <= {{(32-`FWS_IRQ_W){1'b0}}, mask_r};
        `FWS_REG_LAST:     reg_rdata_o <= {16'h0000, prev_r, last_r};
        default:           reg_rdata_o <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata_o <= 32'h0000_0000;
  end

endmodule

/* File: verification/fws_flash_model.sv */
// ---------------------------------------------------------------
// behavioural flash: status byte while busy, array byte otherwise
// ---------------------------------------------------------------
module fws_flash_model
(
  input  wire       ce_n_i,
  input  wire       oe_n_i,
  input  wire       we_n_i,
  input  wire [7:0] dq_i,
  output wire [7:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] arr    = 8'h5A;
  logic [7:0] busy   = 8'h00;
  logic [7:0] hold   = 8'h00;
  logic [7:0] wbyte  = 8'h00;
  logic       tog    = 1'b0;
  logic       fail   = 1'b0;
  logic       win    = 1'b0;
  logic       ers    = 1'b0;
  logic       rd_act = 1'b0;
  logic       wr_act = 1'b0;
  int         wcnt   = 0;
  // status layout while the embedded job runs
  wire  [7:0] cur = (busy != 8'h00) ?
                    {~arr[7], tog, fail, 1'b0, win, tog & ers, 2'b00} : arr;
  // a released bus never keeps the last byte
  assign dq_o = (!ce_n_i && !oe_n_i) ? cur : ~hold;
  // read ends on the output enable rising edge
  always @(negedge oe_n_i) rd_act = !ce_n_i;
  always @(posedge oe_n_i)
  begin
    if (rd_act)
    begin
      hold = cur;
      rd_act = 1'b0;
      if (busy != 8'h00)
      begin
        tog = ~tog;
        busy = busy - 8'h01;
      end
    end
  end
  // command writes: reset and added sector erase
  always @(negedge we_n_i) wr_act = !ce_n_i;
  always @(posedge we_n_i)
  begin
    if (wr_act)
    begin
      wr_act = 1'b0;
      wcnt++;
      wbyte = dq_i;
      if (dq_i == 8'hF0)
      begin
        busy = 8'h00;
        fail = 1'b0;
        ers = 1'b0;
      end
      if (dq_i == 8'h30 && !win) ers = 1'b1;
    end
  end
endmodule

/* File: verification/fws_host_checker.sv */
`include "fws_defines.vh"

module fws_host_checker
#(
  parameter AW = 19
)
(
  input wire          clk_sys_i,
  input wire          nrst_i,
  input wire [3:0]    reg_addr_i,
  input wire [31:0]   reg_wdata_i,
  input wire          reg_wr_i,
  input wire          reg_rd_i,
  input wire [31:0]   reg_rdata_o,
  input wire          irq_o,
  input wire [AW-1:0] fl_addr_o,
  input wire [7:0]    fl_dq_i,
  input wire [7:0]    fl_dq_o,
  input wire          fl_dq_oe_n_o,
  input wire          fl_ce_n_o,
  input wire          fl_oe_n_o,
  input wire          fl_we_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] op_r;
  logic       ign_r;
  logic       ce_q_r;
  logic       we_q_r;
  logic [3:0] rd_n_r;
  wire op_wr = reg_wr_i && reg_addr_i == `FWS_REG_CTRL && reg_wdata_i[2:0] != 3'h0;
  wire rd_go = !fl_ce_n_o && ce_q_r && fl_dq_oe_n_o;
  wire wr_go = !fl_we_n_o && we_q_r;
  wire poll  = op_r == `FWS_OP_POLL;
  wire add   = op_r == `FWS_OP_ADD_SEC;
  // order tracking; abort writes carry no op and are skipped
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      op_r <= 3'h0;
      ign_r <= 1'b0;
      ce_q_r <= 1'b1;
      we_q_r <= 1'b1;
      rd_n_r <= 4'h0;
    end
    else
    begin
      ce_q_r <= fl_ce_n_o;
      we_q_r <= fl_we_n_o;
      if (op_wr)
      begin
        op_r <= reg_wdata_i[2:0];
        ign_r <= reg_wdata_i[`FWS_CTRL_IGN_WIN];
        rd_n_r <= 4'h0;
      end
      else if (rd_go && rd_n_r != 4'hF)
        rd_n_r <= rd_n_r + 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  poll_double_read_a:
    assert property (op_wr && reg_wdata_i[2:0] == `FWS_OP_POLL |-> ##[1:4] rd_go ##[2:8] rd_go)
    else $error("poll did not open with two reads");
  fail_recheck_a:
    assert property (poll && wr_go |-> rd_n_r >= 4'h4) else $error("reset before recheck");
  reset_byte_a:
    assert property ((poll || op_r == `FWS_OP_RESET) && wr_go |->
                     !fl_dq_oe_n_o && fl_dq_o == `FWS_CMD_RESET) else $error("bad reset byte");
  pre_check_a:
    assert property (add && !ign_r && wr_go |-> rd_n_r == 4'h1 && fl_dq_o == `FWS_CMD_SEC_ERASE)
    else $error("erase write without one read before");
  post_check_a:
    assert property (add && !ign_r && wr_go |-> ##[2:10] rd_go) else $error("no read after erase");
  skip_window_a:
    assert property (add && ign_r && !op_wr |-> !rd_go) else $error("window read not skipped");
  ign_write_a:
    assert property (op_wr && reg_wdata_i[2:0] == `FWS_OP_ADD_SEC && reg_wdata_i[4] |->
                     ##[1:6] wr_go) else $error("added erase write missing");
endmodule

/* File: verification/fws_host_bench.sv */
`include "fws_defines.vh"
`define FWS_CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module fws_host_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0] op;
    logic [7:0] busy;
    logic       fail;
    logic       win;
    logic       ign;
    logic [3:0] sts;
    logic [1:0] wcnt;
    logic [7:0] wbyte;
  } fws_row_t;
  logic        clk_sys_i   = 1'b0;
  logic        nrst_i      = 1'b0;
  logic [3:0]  reg_addr_i  = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  wire  [31:0] reg_rdata_o;
  wire         irq_o;
  wire         fl_dq_oe_n_o;
  wire         fl_ce_n_o;
  wire         fl_oe_n_o;
  wire         fl_we_n_o;
  wire  [18:0] fl_addr_o;
  wire  [7:0]  fl_dq_o;
  wire  [7:0]  mdl_dq;
  wire  [7:0]  fl_dq_i;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          w0;
  logic [31:0] d;
  fws_row_t    rows [7];
  // the host wins the bus while its enable is low
  assign fl_dq_i = fl_dq_oe_n_o ? mdl_dq : fl_dq_o;
  always #20 clk_sys_i = ~clk_sys_i;
  fws_host #(.AW(19)) u_dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .fl_addr_o(fl_addr_o), .fl_dq_i(fl_dq_i),
    .fl_dq_o(fl_dq_o), .fl_dq_oe_n_o(fl_dq_oe_n_o), .fl_ce_n_o(fl_ce_n_o),
    .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o));
  fws_flash_model u_flash (.ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o),
                           .dq_i(fl_dq_i), .dq_o(mdl_dq));
  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    d = reg_rdata_o;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  task automatic wait_irq;
    int k;
    k = 0;
    while (irq_o !== 1'b1 && k < 600)
    begin
      @(posedge clk_sys_i);
      k++;
    end
    `FWS_CHK(irq_o, 1'b1)
  endtask
  task automatic load(input logic [7:0] b, input logic f, input logic w);
    u_flash.busy = b;
    u_flash.fail = f;
    u_flash.win = w;
    u_flash.tog = 1'b0;
    u_flash.ers = 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial
  begin
    #400_000;
    n_fail++;
    tally_and_finish;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rows[0] = '{`FWS_OP_POLL, 8'h02, 1'b0, 1'b0, 1'b0, 4'h1, 2'h0, 8'h00};
    rows[1] = '{`FWS_OP_POLL, 8'h03, 1'b0, 1'b0, 1'b0, 4'h1, 2'h0, 8'h00};
    rows[2] = '{`FWS_OP_POLL, 8'hFF, 1'b1, 1'b0, 1'b0, 4'h3, 2'h1, 8'hF0};
    rows[3] = '{`FWS_OP_ADD_SEC, 8'hFF, 1'b0, 1'b0, 1'b0, 4'h1, 2'h1, 8'h30};
    rows[4] = '{`FWS_OP_ADD_SEC, 8'hFF, 1'b0, 1'b1, 1'b0, 4'h5, 2'h0, 8'h30};
    rows[5] = '{`FWS_OP_ADD_SEC, 8'hFF, 1'b0, 1'b1, 1'b1, 4'h1, 2'h1, 8'h30};
    rows[6] = '{`FWS_OP_RESET, 8'h00, 1'b0, 1'b0, 1'b0, 4'h1, 2'h1, 8'hF0};
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(negedge clk_sys_i);
    `FWS_CHK(irq_o, 1'b0)
    reg_rd(`FWS_REG_CTRL);
    `FWS_CHK(d, 32'h0000_0000)
    reg_rd(`FWS_REG_IRQ_MASK);
    `FWS_CHK(d, 32'h0000_0000)
    reg_rd(4'hC);
    `FWS_CHK(d, 32'h0000_0000)
    reg_wr(`FWS_REG_IRQ_MASK, 32'h0000_000F);
    // one order per row: status, flash writes, last written byte
    for (int i = 0; i < 7; i++)
    begin
      load(rows[i].busy, rows[i].fail, rows[i].win);
      w0 = u_flash.wcnt;
      reg_wr(`FWS_REG_CTRL, {27'h0, rows[i].ign, 1'b0, rows[i].op});
      wait_irq;
      reg_rd(`FWS_REG_IRQ_STS);
      `FWS_CHK(d[3:0], rows[i].sts)
      `FWS_CHK(2'(u_flash.wcnt - w0), rows[i].wcnt)
      `FWS_CHK(u_flash.wbyte, rows[i].wbyte)
      reg_wr(`FWS_REG_IRQ_STS, 32'h0000_000F);
      settle;
    end
    // single array read once the job is over
    load(8'h00, 1'b0, 1'b0);
    reg_wr(`FWS_REG_ADDR, 32'h0000_0123);
    reg_wr(`FWS_REG_CTRL, {29'h0, `FWS_OP_READ});
    wait_irq;
    reg_rd(`FWS_REG_RDATA);
    `FWS_CHK(d[7:0], 8'h5A)
    `FWS_CHK(fl_addr_o, 19'h0_0123)
    // single write op puts the data byte on the bus
    reg_wr(`FWS_REG_IRQ_STS, 32'h0000_000F);
    reg_wr(`FWS_REG_WDATA, 32'h0000_00A5);
    reg_wr(`FWS_REG_CTRL, {29'h0, `FWS_OP_WRITE});
    wait_irq;
    `FWS_CHK(u_flash.wbyte, 8'hA5)
    reg_wr(`FWS_REG_IRQ_STS, 32'h0000_000F);
    settle;
    // abort a long poll, then a fresh poll must start over
    load(8'hFF, 1'b0, 1'b0);
    reg_wr(`FWS_REG_CTRL, {29'h0, `FWS_OP_POLL});
    repeat (30) @(posedge clk_sys_i);
    reg_wr(`FWS_REG_CTRL, 32'h0000_0008);
    wait_irq;
    reg_rd(`FWS_REG_IRQ_STS);
    `FWS_CHK(d[3:0], 4'h8)
    reg_wr(`FWS_REG_IRQ_STS, 32'h0000_000F);
    settle;
    load(8'h02, 1'b0, 1'b0);
    reg_wr(`FWS_REG_CTRL, {29'h0, `FWS_OP_POLL});
    wait_irq;
    reg_rd(`FWS_REG_IRQ_STS);
    `FWS_CHK(d[3:0], 4'h1)
    reg_wr(`FWS_REG_IRQ_STS, 32'h0000_000F);
    // reset in mid poll puts address, strobes, data enable and irq back to idle
    load(8'hFF, 1'b0, 1'b0);
    reg_wr(`FWS_REG_CTRL, {29'h0, `FWS_OP_POLL});
    repeat (5) @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(negedge clk_sys_i);
    `FWS_CHK({fl_addr_o, fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_dq_oe_n_o, irq_o}, 24'h00_001E)
    reg_rd(`FWS_REG_CTRL);
    `FWS_CHK(d, 32'h0000_0000)
    // masked event stays sticky without raising the line
    reg_wr(`FWS_REG_IRQ_MASK, 32'h0000_0000);
    reg_wr(`FWS_REG_CTRL, {29'h0, `FWS_OP_RESET});
    repeat (20) @(posedge clk_sys_i);
    `FWS_CHK(irq_o, 1'b0)
    reg_rd(`FWS_REG_IRQ_STS);
    `FWS_CHK(d[0], 1'b1)
    reg_wr(`FWS_REG_IRQ_MASK, 32'h0000_0001);
    settle;
    `FWS_CHK(irq_o, 1'b1)
    reg_wr(`FWS_REG_IRQ_STS, 32'h0000_0001);
    settle;
    `FWS_CHK(irq_o, 1'b0)
    tally_and_finish;
  end
endmodule

bind fws_host fws_host_checker #(.AW(AW)) u_chk (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .fl_addr_o(fl_addr_o), .fl_dq_i(fl_dq_i),
  .fl_dq_o(fl_dq_o), .fl_dq_oe_n_o(fl_dq_oe_n_o), .fl_ce_n_o(fl_ce_n_o),
  .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o));
